//--- ppm_pkg.sv
// Constants shared by the port pin override mux files
package ppm_pkg;
    // Bus register byte offsets
    localparam logic [4:0] ADDR_OUT = 5'h00; // Port output bits
    localparam logic [4:0] ADDR_DIR = 5'h04; // Direction bits
    localparam logic [4:0] ADDR_IN = 5'h08; // Pin value, write one toggles output bit
    localparam logic [4:0] ADDR_CTRL = 5'h0c; // Global controls
    localparam logic [4:0] ADDR_FLAG = 5'h10; // Pin change flags, write one clears
    // Control register field
    localparam int CTRL_PULL_OFF_BIT = 0; // Global pull-up disable
    // Reset values
    localparam logic [7:0] RESET_OUT = 8'h00;
    localparam logic [7:0] RESET_DIR = 8'h00;
    localparam logic RESET_PULL_OFF = 1'h0;
    // Pull-up on when {direction, output, global disable} equals this code
    localparam logic [2:0] PULL_ON_CODE = 3'h2;
    // Synchronizer depth for the readable pin value
    localparam int SYNC_STAGES = 2;
    // Function lanes of the eight-pin port
    localparam int LANE_SS = 0; // Slave select, pin change 0
    localparam int LANE_SCK = 1; // Serial clock, pin change 1
    localparam int LANE_MOSI = 2; // Master out, prog serial data in, pin change 2
    localparam int LANE_MISO = 3; // Master in, prog serial data out, pin change 3
    localparam int LANE_ANALOG_11 = 4; // Analog channel 11, pin change 4
    localparam int LANE_ANALOG_12 = 5; // Timer1 A, timer4 B complement, analog 12
    localparam int LANE_ANALOG_13 = 6; // Timer1 B, timer4 B, analog 13
    localparam int LANE_TIMER0_A = 7; // Timer0 A, timer1 C, pin change 7, flow control
endpackage : ppm_pkg

//--- ppm_sync2.sv
// Two-stage synchronizer for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module ppm_sync2 #(
    parameter int WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    // First stage, read only by the second stage
    logic [WIDTH-1:0] meta;

    // Width must be usable
    if (WIDTH < 1) begin : g_bad_width
        $error("ppm_sync2: WIDTH must be at least 1");
    end

    // Both stages clear on reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= '0;
            sync_o <= '0;
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end
endmodule : ppm_sync2
`default_nettype wire

//--- ppm_pin_cell.sv
// Combinational override mux for one port pin
`timescale 1ns/1ps
`default_nettype none
module ppm_pin_cell (
    input wire logic pin_direction_bit_i,
    input wire logic pin_output_bit_i,
    input wire logic global_pullup_disable_i,
    input wire logic sleep_clamp_i,
    input wire logic irq_enable_i,
    input wire logic pull_override_enable_i,
    input wire logic pull_override_value_i,
    input wire logic dir_override_enable_i,
    input wire logic dir_override_value_i,
    input wire logic value_override_enable_i,
    input wire logic value_override_value_i,
    input wire logic input_en_override_enable_i,
    input wire logic input_en_override_value_i,
    input wire logic pad_level_i,
    output logic pullup_en_o,
    output logic drive_en_o,
    output logic drive_level_o,
    output logic alt_digital_in_o
);
    // Normal-state input enable and final input enable
    wire clamp_active;
    wire input_enable;
    wire [2:0] pull_code;

    // Clamp applies unless the pin's interrupt request is enabled
    assign clamp_active = sleep_clamp_i & ~irq_enable_i;
    // Override ignores the sleep state entirely
    assign input_enable = input_en_override_enable_i ? input_en_override_value_i : ~clamp_active;
    // Clamped input reads as ground ahead of the trigger
    assign alt_digital_in_o = pad_level_i & input_enable;

    // Register-controlled pull-up only in the single input-high code
    assign pull_code = {pin_direction_bit_i, pin_output_bit_i, global_pullup_disable_i};
    assign pullup_en_o = pull_override_enable_i ? pull_override_value_i
                                                : (pull_code == ppm_pkg::PULL_ON_CODE);
    // Driver enable from override or direction bit; low enables fall back to registers
    assign drive_en_o = dir_override_enable_i ? dir_override_value_i : pin_direction_bit_i;
    // Driven level from override or output bit
    assign drive_level_o = value_override_enable_i ? value_override_value_i : pin_output_bit_i;
endmodule : ppm_pin_cell
`default_nettype wire

//--- ppm_port_top.sv
// Port with per-pin peripheral override muxes and a Wishbone register slave
`timescale 1ns/1ps
`default_nettype none
module ppm_port_top #(
    parameter int WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Global sleep clamp from the sleep controller
    input wire logic sleep_clamp_i,
    // Per-pin interrupt request enables
    input wire logic [WIDTH-1:0] irq_enable_i,
    // Per-pin override signals from peripherals
    input wire logic [WIDTH-1:0] pull_override_enable_i,
    input wire logic [WIDTH-1:0] pull_override_value_i,
    input wire logic [WIDTH-1:0] dir_override_enable_i,
    input wire logic [WIDTH-1:0] dir_override_value_i,
    input wire logic [WIDTH-1:0] value_override_enable_i,
    input wire logic [WIDTH-1:0] value_override_value_i,
    input wire logic [WIDTH-1:0] toggle_override_enable_i,
    input wire logic [WIDTH-1:0] input_en_override_enable_i,
    input wire logic [WIDTH-1:0] input_en_override_value_i,
    // Pads
    input wire logic [WIDTH-1:0] pad_i,
    output logic [WIDTH-1:0] pad_o,
    output logic [WIDTH-1:0] pad_oe_o,
    output logic [WIDTH-1:0] pad_pullup_o,
    // Alternate function taps
    output logic [WIDTH-1:0] alt_digital_in_o,
    output logic [WIDTH-1:0] alt_analog_io_o,
    output logic spi_ss_in_o,
    output logic spi_sck_in_o,
    output logic spi_mosi_in_o,
    output logic spi_miso_in_o,
    output logic analog_channel_11_o,
    output logic analog_channel_12_o,
    output logic analog_channel_13_o
);
    // Port state registers
    logic [WIDTH-1:0] pin_output_bit; // Stored output bits
    logic [WIDTH-1:0] pin_direction_bit; // Stored direction bits
    logic global_pullup_disable; // Shared by all pins
    logic [WIDTH-1:0] change_flag; // Sticky pin change flags
    logic [WIDTH-1:0] pin_value; // Synchronized pin value
    logic [WIDTH-1:0] pin_value_prev; // Previous synchronized value

    // Combinational pin cell results
    wire [WIDTH-1:0] cell_pullup;
    wire [WIDTH-1:0] cell_drive_en;
    wire [WIDTH-1:0] cell_drive_level;
    wire [WIDTH-1:0] cell_din;

    // Bus decode
    wire bus_req;
    wire bus_commit;
    wire wr_commit;
    wire sel_low;
    wire hit_out;
    wire hit_dir;
    wire hit_in;
    wire hit_ctrl;
    wire hit_flag;
    wire [WIDTH-1:0] wr_bits;
    wire [WIDTH-1:0] pin_toggle;
    wire [WIDTH-1:0] next_pin_output_bit;
    wire [WIDTH-1:0] next_change_flag;
    wire [WIDTH-1:0] change_event;
    wire [31:0] next_rd_data;

    // Width must fit a bus word
    if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
        $error("ppm_port_top: WIDTH must be 1 to 32");
    end

    // Widen a port-wide vector into a bus word
    function automatic logic [31:0] to_word(input logic [WIDTH-1:0] v);
        logic [31:0] w;
        w = '0;
        w[WIDTH-1:0] = v;
        return w;
    endfunction : to_word

    // One mux per pin; strobes and globals fan to all pins
    for (genvar n = 0; n < WIDTH; n++) begin : g_pin
        ppm_pin_cell u_cell (
            .pin_direction_bit_i(pin_direction_bit[n]),
            .pin_output_bit_i(pin_output_bit[n]),
            .global_pullup_disable_i(global_pullup_disable),
            .sleep_clamp_i(sleep_clamp_i),
            .irq_enable_i(irq_enable_i[n]),
            .pull_override_enable_i(pull_override_enable_i[n]),
            .pull_override_value_i(pull_override_value_i[n]),
            .dir_override_enable_i(dir_override_enable_i[n]),
            .dir_override_value_i(dir_override_value_i[n]),
            .value_override_enable_i(value_override_enable_i[n]),
            .value_override_value_i(value_override_value_i[n]),
            .input_en_override_enable_i(input_en_override_enable_i[n]),
            .input_en_override_value_i(input_en_override_value_i[n]),
            .pad_level_i(pad_i[n]),
            .pullup_en_o(cell_pullup[n]),
            .drive_en_o(cell_drive_en[n]),
            .drive_level_o(cell_drive_level[n]),
            .alt_digital_in_o(cell_din[n])
        );
    end

    // Readable value passes two flops after the gated input
    ppm_sync2 #(
        .WIDTH(WIDTH)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(cell_din),
        .sync_o(pin_value)
    );

    // Unsynchronized tap; receivers resynchronize unless used as a clock
    assign alt_digital_in_o = cell_din;
    // Analog path is the raw pad, no gating in the way
    assign alt_analog_io_o = pad_i;

    // Function taps of the port; timer and flow-control outputs enter via value overrides
    assign spi_ss_in_o = cell_din[ppm_pkg::LANE_SS];
    assign spi_sck_in_o = cell_din[ppm_pkg::LANE_SCK];
    assign spi_mosi_in_o = cell_din[ppm_pkg::LANE_MOSI]; // Also programming data
    assign spi_miso_in_o = cell_din[ppm_pkg::LANE_MISO]; // Also programming data out lane
    assign analog_channel_11_o = pad_i[ppm_pkg::LANE_ANALOG_11];
    assign analog_channel_12_o = pad_i[ppm_pkg::LANE_ANALOG_12];
    assign analog_channel_13_o = pad_i[ppm_pkg::LANE_ANALOG_13];

    // Bus request, commit on the edge where ack is seen high
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign bus_commit = bus_req & wb_ack_o;
    assign wr_commit = bus_commit & wb_we_i;
    assign sel_low = wb_sel_i[0] | (WIDTH > 8 ? |wb_sel_i[3:1] : 1'b0);
    assign wr_bits = wb_dat_i[WIDTH-1:0];

    // Address decode, one shared strobe per register
    assign hit_out = wb_adr_i == ppm_pkg::ADDR_OUT;
    assign hit_dir = wb_adr_i == ppm_pkg::ADDR_DIR;
    assign hit_in = wb_adr_i == ppm_pkg::ADDR_IN;
    assign hit_ctrl = wb_adr_i == ppm_pkg::ADDR_CTRL;
    assign hit_flag = wb_adr_i == ppm_pkg::ADDR_FLAG;

    // Writing ones to the pin register toggles output bits
    assign pin_toggle = (wr_commit & sel_low & hit_in) ? wr_bits : '0;
    // Direct write first, then software and peripheral toggles
    assign next_pin_output_bit = ((wr_commit & sel_low & hit_out) ? wr_bits : pin_output_bit)
                                 ^ pin_toggle ^ toggle_override_enable_i;

    // Any settled change flags; clamp release on a high pin shows here
    assign change_event = pin_value ^ pin_value_prev;
    // Set wins over a write-one clear
    assign next_change_flag = ((wr_commit & sel_low & hit_flag) ? (change_flag & ~wr_bits) : change_flag)
                              | change_event;

    // Read mux; unmapped offsets read zero
    assign next_rd_data = hit_out ? to_word(pin_output_bit) :
                          hit_dir ? to_word(pin_direction_bit) :
                          hit_in ? to_word(pin_value) :
                          hit_ctrl ? (32'(global_pullup_disable) << ppm_pkg::CTRL_PULL_OFF_BIT) :
                          hit_flag ? to_word(change_flag) : 32'h0;

    // Ack one cycle after request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            wb_dat_o <= next_rd_data;
        end
    end

    // Output bits, stored state toggled in place
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_output_bit <= WIDTH'(ppm_pkg::RESET_OUT);
        end else begin
            pin_output_bit <= next_pin_output_bit;
        end
    end

    // Direction and global pull-up disable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_direction_bit <= WIDTH'(ppm_pkg::RESET_DIR);
            global_pullup_disable <= ppm_pkg::RESET_PULL_OFF;
        end else if (wr_commit & sel_low) begin
            if (hit_dir) begin
                pin_direction_bit <= wr_bits;
            end
            if (hit_ctrl) begin
                global_pullup_disable <= wb_dat_i[ppm_pkg::CTRL_PULL_OFF_BIT];
            end
        end
    end

    // Change flags and previous value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            change_flag <= '0;
            pin_value_prev <= '0;
        end else begin
            change_flag <= next_change_flag;
            pin_value_prev <= pin_value;
        end
    end

    // Pad drivers; pull-ups and drivers off while reset holds
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pad_pullup_o <= '0;
            pad_oe_o <= '0;
            pad_o <= '0;
        end else begin
            pad_pullup_o <= cell_pullup;
            pad_oe_o <= cell_drive_en;
            pad_o <= cell_drive_level;
        end
    end

    // Checks on lane 0 stand for every pin
    pullup_reset_a: assert property (@(posedge clk_i) rst_i |=> pad_pullup_o == '0)
        else $error("pull-up on after reset");

    pull_mux_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 pad_pullup_o[0] == ($past(pull_override_enable_i[0]) ? $past(pull_override_value_i[0])
            : ({$past(pin_direction_bit[0]), $past(pin_output_bit[0]), $past(global_pullup_disable)}
               == ppm_pkg::PULL_ON_CODE)))
        else $error("pull-up does not follow its controls");

    drive_mux_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 pad_oe_o[0] == ($past(dir_override_enable_i[0]) ? $past(dir_override_value_i[0])
                                                             : $past(pin_direction_bit[0])))
        else $error("driver enable wrong");

    level_mux_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 pad_o[0] == ($past(value_override_enable_i[0]) ? $past(value_override_value_i[0])
                                                            : $past(pin_output_bit[0])))
        else $error("driven level wrong");

    toggle_ovr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        toggle_override_enable_i[0] && !wr_commit |=> pin_output_bit[0] != $past(pin_output_bit[0]))
        else $error("toggle override did not invert");

    pin_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_commit && hit_in && sel_low && wb_dat_i[0] && !toggle_override_enable_i[0]
        |=> pin_output_bit[0] != $past(pin_output_bit[0]))
        else $error("pin write did not toggle");

    sleep_clamp_a: assert property (@(posedge clk_i) disable iff (rst_i)
        sleep_clamp_i |-> (alt_digital_in_o & ~input_en_override_enable_i & ~irq_enable_i) == '0)
        else $error("clamped input not grounded");

    sync_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ##2 pin_value[0] == $past(cell_din[0], 2))
        else $error("pin value not two stages late");

    change_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(pin_value[0]) |=> change_flag[0])
        else $error("rising pin did not set flag");

    bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack timing wrong");

    // Main scenarios
    clamp_wake_c: cover property (@(posedge clk_i) disable iff (rst_i)
        sleep_clamp_i ##1 !sleep_clamp_i ##[1:4] change_flag[7]);
    override_drive_c: cover property (@(posedge clk_i) disable iff (rst_i)
        dir_override_enable_i[0] && value_override_enable_i[0]);
    pin_toggle_c: cover property (@(posedge clk_i) disable iff (rst_i) wr_commit && hit_in);
endmodule : ppm_port_top
`default_nettype wire

//--- ppm_periph_model.sv
// Peripheral stand-in that drives the per-pin override signals
`timescale 1ns/1ps
`default_nettype none
module ppm_periph_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [7:0] mask_i,
    input wire logic [8:0] cfg_i,
    output logic [7:0] pull_override_enable_o,
    output logic [7:0] pull_override_value_o,
    output logic [7:0] dir_override_enable_o,
    output logic [7:0] dir_override_value_o,
    output logic [7:0] value_override_enable_o,
    output logic [7:0] value_override_value_o,
    output logic [7:0] toggle_override_enable_o,
    output logic [7:0] input_en_override_enable_o,
    output logic [7:0] input_en_override_value_o
);
    logic [7:0] mask; // Pins this peripheral owns
    logic [8:0] cfg; // Internal function state
    logic tog; // One-shot toggle request
    // Take new state; toggle lasts one cycle, since a held one inverts every clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask <= 8'h00;
            cfg <= 9'h000;
            tog <= 1'b0;
        end else if (load_i) begin
            mask <= mask_i;
            cfg <= cfg_i;
            tog <= cfg_i[2];
        end else begin
            tog <= 1'b0;
        end
    end
    // Overrides come from own state; pins outside the mask stay low
    assign pull_override_enable_o = mask & {8{cfg[8]}};
    assign pull_override_value_o = mask & {8{cfg[7]}};
    assign dir_override_enable_o = mask & {8{cfg[6]}};
    assign dir_override_value_o = mask & {8{cfg[5]}};
    assign value_override_enable_o = mask & {8{cfg[4]}};
    assign value_override_value_o = mask & {8{cfg[3]}};
    assign toggle_override_enable_o = mask & {8{tog}};
    assign input_en_override_enable_o = mask & {8{cfg[1]}};
    assign input_en_override_value_o = mask & {8{cfg[0]}};
endmodule : ppm_periph_model
`default_nettype wire

//--- port_pin_override_mux_tb.sv
// Self-checking bench for the port pin override mux
`timescale 1ns/1ps
`default_nettype none
module port_pin_override_mux_tb;
    logic clk_i;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, rdat;
    logic ack, sleep = 1'b0, load = 1'b0;
    logic [7:0] irq = 8'h00, pad = 8'h00, mask = 8'h00;
    logic [8:0] cfg = 9'h000;
    logic [7:0] pu_en, pu_val, dd_en, dd_val, pv_en, pv_val, tg_en, ie_en, ie_val;
    logic [7:0] pad_o, pad_oe, pad_pu, alt_din, alt_an;
    logic ss, sck, mosi, miso, an11, an12, an13;
    int fails = 0, check_count = 0;
    // Rows: dir, out, pud, six overrides, then expected pull-up, driver enable, level
    localparam logic [11:0] ROWS [9] = '{12'h404, 12'h600, 12'hc03, 12'h184, 12'h500,
        12'h07b, 12'hc40, 12'hc12, 12'h81b};
    ppm_periph_model peer (.clk_i(clk_i), .rst_i(rst_i), .load_i(load), .mask_i(mask), .cfg_i(cfg),
        .pull_override_enable_o(pu_en), .pull_override_value_o(pu_val), .dir_override_enable_o(dd_en),
        .dir_override_value_o(dd_val), .value_override_enable_o(pv_en), .value_override_value_o(pv_val),
        .toggle_override_enable_o(tg_en), .input_en_override_enable_o(ie_en),
        .input_en_override_value_o(ie_val));
    ppm_port_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .sleep_clamp_i(sleep), .irq_enable_i(irq), .pull_override_enable_i(pu_en),
        .pull_override_value_i(pu_val), .dir_override_enable_i(dd_en), .dir_override_value_i(dd_val),
        .value_override_enable_i(pv_en), .value_override_value_i(pv_val),
        .toggle_override_enable_i(tg_en), .input_en_override_enable_i(ie_en),
        .input_en_override_value_i(ie_val), .pad_i(pad), .pad_o(pad_o), .pad_oe_o(pad_oe),
        .pad_pullup_o(pad_pu), .alt_digital_in_o(alt_din), .alt_analog_io_o(alt_an), .spi_ss_in_o(ss),
        .spi_sck_in_o(sck), .spi_mosi_in_o(mosi), .spi_miso_in_o(miso), .analog_channel_11_o(an11),
        .analog_channel_12_o(an12), .analog_channel_13_o(an13));
    // Free-running 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // One comparison; four-state equality so an unknown never matches a known value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Classic single cycle; held until ack is sampled high at a rising edge, released at that edge
    task automatic wb_cycle(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        // Only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb_cycle
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_cycle(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb_cycle(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask : rd
    // Hand the peripheral a new function state
    task automatic ld(input logic [7:0] m, input logic [8:0] c);
        @(posedge clk_i);
        load <= 1'b1;
        mask <= m;
        cfg <= c;
        @(posedge clk_i);
        load <= 1'b0;
    endtask : ld
    // Registered pin outputs and the synchronizer need a few edges
    task automatic settle;
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
    endtask : settle
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    // Watchdog; the whole run needs far less than this
    initial begin
        #100000;
        fails++;
        $display("mismatch at %0t: timeout", $time);
        stop_test();
    end
    // Main sequence
    initial begin
        logic [11:0] r;
        logic [7:0] e_pu, e_oe, e_lv;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(ppm_pkg::ADDR_OUT, 32'h0);
        rd(ppm_pkg::ADDR_DIR, 32'h0);
        rd(ppm_pkg::ADDR_CTRL, 32'h0);
        chk(32'(pad_pu), 32'h0);
        // Every override row on pins 1,3,4,6; the rest stay plain
        for (int i = 0; i < 9; i++) begin
            r = ROWS[i];
            wr(ppm_pkg::ADDR_OUT, {24'h0, {8{r[10]}}});
            wr(ppm_pkg::ADDR_DIR, {24'h0, {8{r[11]}}});
            wr(ppm_pkg::ADDR_CTRL, 32'(r[9]) << ppm_pkg::CTRL_PULL_OFF_BIT);
            ld(8'h5a, {r[8:3], 3'h0});
            settle();
            e_pu = (8'h5a & {8{r[2]}}) | (8'ha5 & {8{!r[11] && r[10] && !r[9]}});
            e_oe = (8'h5a & {8{r[1]}}) | (8'ha5 & {8{r[11]}});
            e_lv = (8'h5a & {8{r[0]}}) | (8'ha5 & {8{r[10]}});
            chk(32'(pad_pu), 32'(e_pu));
            chk(32'(pad_oe), 32'(e_oe));
            chk(32'(pad_o & e_oe), 32'(e_lv & e_oe));
        end
        // Software pull-up, then a mid-run reset must drop it
        ld(8'h00, 9'h000);
        wr(ppm_pkg::ADDR_OUT, 32'hff);
        wr(ppm_pkg::ADDR_DIR, 32'h0);
        wr(ppm_pkg::ADDR_CTRL, 32'h0);
        settle();
        chk(32'(pad_pu), 32'hff);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        chk(32'(pad_pu), 32'h0);
        @(posedge clk_i);
        rst_i <= 1'b0;
        // Pin-bit write toggles, then the peripheral toggle inverts once more
        wr(ppm_pkg::ADDR_OUT, 32'h0f);
        wr(ppm_pkg::ADDR_DIR, 32'hff);
        wr(ppm_pkg::ADDR_IN, 32'h3d);
        rd(ppm_pkg::ADDR_OUT, 32'h32);
        ld(8'h5b, 9'h004);
        settle();
        rd(ppm_pkg::ADDR_OUT, 32'h69);
        chk(32'(pad_o), 32'h69);
        // Deep sleep clamp with interrupt exemption on the low nibble
        wr(ppm_pkg::ADDR_DIR, 32'h0);
        @(posedge clk_i);
        pad <= 8'hb7;
        sleep <= 1'b1;
        irq <= 8'h0f;
        ld(8'h00, 9'h000);
        settle();
        chk(32'(alt_din), 32'h07);
        rd(ppm_pkg::ADDR_IN, 32'h07);
        chk({28'h0, miso, mosi, sck, ss}, 32'h7);
        chk({24'h0, alt_an}, 32'hb7);
        chk({29'h0, an13, an12, an11}, 32'h3);
        ld(8'h5a, 9'h003);
        settle();
        chk(32'(alt_din), 32'h17);
        @(posedge clk_i);
        sleep <= 1'b0;
        ld(8'h5a, 9'h002);
        settle();
        chk(32'(alt_din), 32'ha5);
        // Clamp release on high pins without interrupt enable raises flags
        @(posedge clk_i);
        pad <= 8'hff;
        sleep <= 1'b1;
        ld(8'h00, 9'h000);
        settle();
        wr(ppm_pkg::ADDR_FLAG, 32'hff);
        rd(ppm_pkg::ADDR_FLAG, 32'h0);
        @(posedge clk_i);
        sleep <= 1'b0;
        settle();
        rd(ppm_pkg::ADDR_FLAG, 32'hf0);
        // Unmapped place acks, ignores writes and reads zero
        wr(5'h14, 32'hff);
        rd(5'h14, 32'h0);
        stop_test();
    end
endmodule : port_pin_override_mux_tb
`default_nettype wire
